// ### rtl/brfm_pkg.sv
// package: address map, field positions and carrier types of the banked register file
package brfm_pkg;
    // data width and address width seen by the core
    localparam int BRFM_DW = 8;
    localparam int BRFM_DIR_AW = 7;
    localparam int BRFM_AW = 8;
    // bank 0 locations (low seven bits)
    localparam logic [6:0] OFS_INDIRECT_DATA_PORT = 7'h00;
    localparam logic [6:0] OFS_TIMER_COUNT = 7'h01;
    localparam logic [6:0] OFS_PROGRAM_COUNTER_LOW = 7'h02;
    localparam logic [6:0] OFS_CORE_FLAGS = 7'h03;
    localparam logic [6:0] OFS_INDIRECT_POINTER = 7'h04;
    localparam logic [6:0] OFS_PORT_PINS = 7'h05;
    localparam logic [6:0] OFS_PROGRAM_COUNTER_LATCH_HIGH = 7'h0A;
    localparam logic [6:0] OFS_INTERRUPT_CONTROL = 7'h0B;
    localparam logic [6:0] OFS_PERIPHERAL_IRQ_FLAGS = 7'h0C;
    localparam logic [6:0] OFS_CONVERSION_RESULT = 7'h1E;
    localparam logic [6:0] OFS_CONVERTER_CONTROL_A = 7'h1F;
    // bank 1 locations (full eight-bit address)
    localparam logic [7:0] OFS_OPTION_CONFIG = 8'h81;
    localparam logic [7:0] OFS_PORT_DIRECTION = 8'h85;
    localparam logic [7:0] OFS_PERIPHERAL_IRQ_ENABLE = 8'h8C;
    localparam logic [7:0] OFS_POWER_CONTROL = 8'h8E;
    localparam logic [7:0] OFS_OSCILLATOR_TRIM = 8'h8F;
    localparam logic [7:0] OFS_CONVERTER_CONTROL_B = 8'h9F;
    // general purpose ram windows
    localparam logic [7:0] GPR0_LO = 8'h20;
    localparam logic [7:0] GPR0_HI = 8'h7F;
    localparam logic [7:0] GPR1_LO = 8'hA0;
    localparam logic [7:0] GPR1_HI = 8'hBF;
    localparam logic [7:0] COMMON_LO = 8'hF0;
    localparam logic [7:0] COMMON_HI = 8'hFF;
    // bank select bit position inside core_flags
    localparam int BANK_SELECT_BIT_POS = 5;
    // storage slots: 17 sfr slots, 96 bank 0 ram, 32 bank 1 ram
    localparam int SFR_SLOTS = 17;
    localparam int GPR0_SLOTS = 96;
    localparam int GPR1_SLOTS = 32;
    localparam int SLOTS = 145;
    localparam int IDX_W = 8;
    localparam logic [7:0] IDX_GPR0 = 8'h11;
    localparam logic [7:0] IDX_GPR1 = 8'h71;
    localparam logic [7:0] IDX_NONE = 8'hFF;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h18;
    // one core access
    typedef struct packed {
        logic rd;
        logic wr;
        logic indirect;
        logic [6:0] addr;
        logic [7:0] wdata;
    } brfm_req_s;
    // result of decoding one full address
    typedef struct packed {
        logic hit;
        logic [7:0] idx;
    } brfm_dec_s;
endpackage

// ### rtl/brfm_decode.sv
// decoder: maps a full eight-bit file address to a storage slot
`timescale 1ns/1ns
module brfm_decode
    import brfm_pkg::*;
(
    // full address, bank bit on top
    input wire logic [7:0] addr_in,
    // slot and hit flag
    output brfm_dec_s dec_out
);
    // slot lookup for a full eight-bit address, bank bit on top
    function automatic logic [7:0] sfr_slot(input logic [7:0] a);
        logic [7:0] s;
        s = IDX_NONE;
        // mirrored core registers land on one slot whatever the bank
        unique case (a[6:0])
            OFS_PROGRAM_COUNTER_LOW: s = 8'h01; // RULE_07
            OFS_CORE_FLAGS: s = 8'h02; // RULE_07
            OFS_INDIRECT_POINTER: s = 8'h03; // RULE_07
            OFS_PROGRAM_COUNTER_LATCH_HIGH: s = 8'h04; // RULE_07
            OFS_INTERRUPT_CONTROL: s = 8'h05; // RULE_07
            default: s = IDX_NONE;
        endcase
        if (s == IDX_NONE && !a[7])
        begin
            // bank 0 only registers
            unique case (a[6:0])
                OFS_TIMER_COUNT: s = 8'h00;
                OFS_PORT_PINS: s = 8'h06;
                OFS_PERIPHERAL_IRQ_FLAGS: s = 8'h07;
                OFS_CONVERSION_RESULT: s = 8'h08;
                OFS_CONVERTER_CONTROL_A: s = 8'h09;
                default: s = IDX_NONE;
            endcase
        end
        else if (s == IDX_NONE)
        begin
            // bank 1 only registers
            unique case (a)
                OFS_OPTION_CONFIG: s = 8'h0A;
                OFS_PORT_DIRECTION: s = 8'h0B;
                OFS_PERIPHERAL_IRQ_ENABLE: s = 8'h0C;
                OFS_POWER_CONTROL: s = 8'h0D;
                OFS_OSCILLATOR_TRIM: s = 8'h0E;
                OFS_CONVERTER_CONTROL_B: s = 8'h0F;
                default: s = IDX_NONE;
            endcase
        end
        return s;
    endfunction

    // pure combinational decode
    always_comb
    begin
        dec_out.idx = sfr_slot(addr_in);
        if (addr_in >= GPR0_LO && addr_in <= GPR0_HI)
        begin
            // bank 0 ram, 20h..7Fh
            dec_out.idx = IDX_GPR0 + (addr_in - GPR0_LO); // RULE_08
        end
        else if (addr_in >= COMMON_LO)
        begin
            // common ram: same slot as bank 0 70h..7Fh
            dec_out.idx = IDX_GPR0 + (addr_in - COMMON_LO) + 8'h50; // RULE_06
        end
        else if (addr_in >= GPR1_LO && addr_in <= GPR1_HI)
        begin
            // bank 1 ram, A0h..BFh
            dec_out.idx = IDX_GPR1 + (addr_in - GPR1_LO); // RULE_08
        end
        // everything else stays unimplemented
        dec_out.hit = (dec_out.idx != IDX_NONE); // RULE_02
    end
endmodule

// ### rtl/brfm_top.sv
// top: two-bank data register file with direct and indirect access
`timescale 1ns/1ns
// Functional notes
// RULE_01 - direct address or indirect pointer access
// RULE_02 - unimplemented locations always read zero
// RULE_03 - indirect data port has no storage
// RULE_04 - special registers are static storage cells
// RULE_05 - bank select bit picks direct bank
// RULE_06 - F0h..FFh share bank 0 70h..7Fh
// RULE_07 - core registers mirrored in both banks
// RULE_08 - ram at 20h up and A0h..BFh
module brfm_top
    import brfm_pkg::*;
(
    // clock and reset
    input wire logic MCLK_IN,
    input wire logic RESETN_IN,
    // core access request
    input wire logic RD_IN,
    input wire logic WR_IN,
    input wire logic [6:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    // read answer
    output logic [7:0] RDATA_OUT,
    output logic RVALID_OUT,
    // state seen by the core
    output logic [7:0] POINTER_OUT,
    output logic BANK_OUT
);
    // reset release pipeline
    logic rst_meta_reg;
    logic rst_sync_reg;
    // storage, flip-flops addressed by slot
    logic [7:0] mem_reg [SLOTS];
    logic [7:0] mem_next [SLOTS];
    // registered answer
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    // decoded request
    brfm_req_s req;
    logic [7:0] full_addr;
    brfm_dec_s dec;
    logic ind_sel;

    // async assert, two-flop release
    always_ff @(posedge MCLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // bundle the request
    always_comb
    begin
        req.rd = RD_IN;
        req.wr = WR_IN;
        req.indirect = (ADDR_IN == OFS_INDIRECT_DATA_PORT); // RULE_03
        req.addr = ADDR_IN;
        req.wdata = WDATA_IN;
    end

    // effective address; pointer slot 3, flags slot 2
    always_comb
    begin
        ind_sel = req.indirect;
        if (ind_sel)
        begin
            // whole eight-bit pointer selects the location
            full_addr = mem_reg[3]; // RULE_01 RULE_03
        end
        else
        begin
            // direct: bank bit on top of the seven instruction bits
            full_addr = {mem_reg[2][BANK_SELECT_BIT_POS], req.addr}; // RULE_01 RULE_05
        end
    end

    // one shared decoder
    brfm_decode u_dec
    (
        .addr_in(full_addr),
        .dec_out(dec)
    );

    // next state of storage and answer
    always_comb
    begin
        for (int i = 0; i < SLOTS; i++)
        begin
            mem_next[i] = mem_reg[i]; // RULE_04
        end
        rdata_next = rdata_reg;
        rvalid_next = req.rd;
        if (req.rd)
        begin
            // a pointer aimed at the port itself has no storage, reads zero
            if (dec.hit)
            begin
                rdata_next = mem_reg[dec.idx];
            end
            else
            begin
                rdata_next = DATA_ZERO; // RULE_02 RULE_03
            end
        end
        if (req.wr && dec.hit)
        begin
            // writes to unimplemented locations are dropped
            mem_next[dec.idx] = req.wdata; // RULE_04 RULE_06 RULE_07
        end
    end

    // registers only; reset clears every storage slot, then loads the flags and pointer reset values
    always_ff @(posedge MCLK_IN or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            for (int i = 0; i < SLOTS; i++)
            begin
                mem_reg[i] <= DATA_ZERO;
            end
            mem_reg[2] <= FLAGS_RESET;
            mem_reg[3] <= PTR_RESET;
            rdata_reg <= DATA_ZERO;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < SLOTS; i++)
            begin
                mem_reg[i] <= mem_next[i];
            end
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // outputs straight from flip-flops
    assign RDATA_OUT = rdata_reg;
    assign RVALID_OUT = rvalid_reg;
    assign POINTER_OUT = mem_reg[3];
    assign BANK_OUT = mem_reg[2][BANK_SELECT_BIT_POS];

    // checks: all on the core clock, quiet while the internal reset is low

    // a write that lands on real storage
    sequence s_store_write;
        WR_IN && dec.hit;
    endsequence
    // two cycles with no write at all, so nothing may overwrite the slot
    sequence s_two_idle;
        (!WR_IN)[*2];
    endsequence

    // unimplemented reads answer zero one cycle later
    a_unimpl_reads_zero: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        (RD_IN && !dec.hit) |=> (RDATA_OUT == 8'h00 && RVALID_OUT)) // RULE_02
        else $error("unimplemented read not zero");

    // the mux must route the pointer, not the instruction bits
    a_indirect_uses_ptr: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        (ADDR_IN == 7'h00) |-> (full_addr == POINTER_OUT)) // RULE_01
        else $error("indirect address not pointer");

    // direct accesses carry the bank bit on top
    a_direct_bank_sel: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        (ADDR_IN != 7'h00) |-> (full_addr[7] == BANK_OUT && full_addr[6:0] == ADDR_IN)) // RULE_05
        else $error("direct bank wrong");

    // a pointer aimed at either port location finds no storage
    a_port_no_store: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        (full_addr[6:0] == 7'h00) |-> !dec.hit) // RULE_03
        else $error("indirect port has storage");

    // the common window folds onto the top of bank 0 ram
    a_common_ram_map: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        (full_addr >= 8'hF0) |-> (dec.idx == IDX_GPR0 + full_addr - 8'h80 - 8'h20)) // RULE_06
        else $error("common ram mapping wrong");

    // pointer reached from either bank lands on one slot
    a_mirror_same_slot: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        (full_addr[6:0] == 7'h04) |-> (dec.idx == 8'h03)) // RULE_07
        else $error("pointer mirror wrong");

    // flags reached from either bank land on one slot
    a_mirror_flags: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        (full_addr[6:0] == OFS_CORE_FLAGS) |-> (dec.idx == 8'h02)) // RULE_07
        else $error("flags mirror wrong");

    // a stored byte survives two quiet cycles untouched
    a_write_holds: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        s_store_write ##1 s_two_idle |-> mem_reg[$past(dec.idx, 2)] == $past(WDATA_IN, 2)) // RULE_04
        else $error("stored value lost");

    // a write to real storage is visible on the next cycle
    a_write_lands: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        s_store_write |=> (mem_reg[$past(dec.idx)] == $past(WDATA_IN))) // RULE_04
        else $error("write did not land");

    // a dropped write must not leak into the pointer or the bank select bit
    a_dropped_write_quiet: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        (WR_IN && !dec.hit) |=> ($stable(POINTER_OUT) && $stable(BANK_OUT))) // RULE_03
        else $error("dropped write changed state");

    // every read is answered exactly one cycle later
    a_read_answer_pulse: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        RD_IN |=> RVALID_OUT) // RULE_01
        else $error("read not answered");

    // no answer without a read
    a_no_spurious_valid: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        !RD_IN |=> !RVALID_OUT) // RULE_01
        else $error("valid without read");

    // the answer stands until the next read, writes leave it alone
    a_read_data_holds: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        !RD_IN |=> $stable(RDATA_OUT)) // RULE_04
        else $error("read data moved");

    // the gap between bank 1 ram and the common window stays empty
    a_bank1_gap: assert property (@(posedge MCLK_IN) disable iff (!rst_sync_reg)
        (full_addr >= 8'hC0 && full_addr < 8'hF0) |-> !dec.hit) // RULE_08
        else $error("bank 1 gap implemented");
endmodule

// ### verif/brfm_core_model.sv
// core-side model: issues one register file access per call
`timescale 1ns/1ns
module brfm_core_model
    import brfm_pkg::*;
(
    // clock
    input wire logic clk_in,
    // request to the file
    output logic rd_out,
    output logic wr_out,
    output logic [6:0] addr_out,
    output logic [7:0] wdata_out,
    // answer from the file
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in
);
    // idle values at time zero
    initial
    begin
        rd_out = 1'b0;
        wr_out = 1'b0;
        addr_out = 7'h06;
        wdata_out = 8'h00;
    end
    // request held up to the taking edge, then strobes dropped and address and data inverted
    task automatic access(input logic r, input logic w, input logic [6:0] a,
                          input logic [7:0] d, output logic [7:0] q, output logic v);
        @(posedge clk_in);
        rd_out <= r;
        wr_out <= w;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
        #1;
        q = rdata_in;
        v = rvalid_in;
    endtask
endmodule

// ### verif/brfm_top_bench.sv
// bench: register file driven through the core-side model
`timescale 1ns/1ns
module brfm_top_bench
    import brfm_pkg::*;
;
    logic mclk, resetn, rd, wr, rvalid, bank, v;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, pointer, q;
    int failures, compares;
    // plain storage locations, bank 0 then bank 1
    logic [6:0] regs0 [8] = '{7'h01, 7'h02, 7'h05, 7'h0A, 7'h0B, 7'h0C, 7'h1E, 7'h1F};
    logic [6:0] regs1 [6] = '{7'h01, 7'h05, 7'h0C, 7'h0E, 7'h0F, 7'h1F};
    // holes in the map
    logic [6:0] holes [5] = '{7'h06, 7'h0D, 7'h1D, 7'h40, 7'h6F};
    // bank 0 holes: all below the ram, bank 1 only slots among them
    logic [6:0] holes0 [5] = '{7'h06, 7'h0D, 7'h0E, 7'h0F, 7'h1D};
    brfm_top dut_u (.MCLK_IN(mclk), .RESETN_IN(resetn), .RD_IN(rd), .WR_IN(wr),
        .ADDR_IN(addr), .WDATA_IN(wdata), .RDATA_OUT(rdata), .RVALID_OUT(rvalid),
        .POINTER_OUT(pointer), .BANK_OUT(bank));
    brfm_core_model core_u (.clk_in(mclk), .rd_out(rd), .wr_out(wr), .addr_out(addr),
        .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_op(input logic [6:0] a, input logic [7:0] d);
        core_u.access(1'b0, 1'b1, a, d, q, v);
    endtask
    // read, then the valid pulse must be gone a cycle later
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        core_u.access(1'b1, 1'b0, a, 8'h00, q, v);
        chk({7'h00, v}, 8'h01);
        chk(q, exp);
        @(posedge mclk);
        #1;
        chk({7'h00, rvalid}, 8'h00);
    endtask
    task automatic report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // 125 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // hang guard
    initial
    begin
        repeat (6000) @(posedge mclk);
        failures++;
        $display("[FAIL] %0t run did not finish", $time);
        report_and_stop();
    end
    initial
    begin
        failures = 0;
        compares = 0;
        resetn = 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(pointer, 8'h00);
        rd_chk(7'h03, 8'h18);
        foreach (regs0[i]) wr_op(regs0[i], 8'h50 + 8'(i));
        foreach (regs0[i]) rd_chk(regs0[i], 8'h50 + 8'(i));
        wr_op(7'h03, 8'h38);
        chk({7'h00, bank}, 8'h01);
        foreach (regs1[i]) wr_op(regs1[i], 8'hA0 + 8'(i));
        foreach (regs1[i]) rd_chk(regs1[i], 8'hA0 + 8'(i));
        rd_chk(7'h02, 8'h51);
        rd_chk(7'h0A, 8'h53);
        rd_chk(7'h0B, 8'h54);
        rd_chk(7'h03, 8'h38);
        wr_op(7'h04, 8'hA0);
        chk(pointer, 8'hA0);
        // bank 1 holes, the C0h..EFh gap among them
        foreach (holes[i]) wr_op(holes[i], 8'hFF);
        foreach (holes[i]) rd_chk(holes[i], 8'h00);
        wr_op(7'h20, 8'h11);
        wr_op(7'h3F, 8'h22);
        wr_op(7'h70, 8'h33);
        wr_op(7'h7F, 8'h44);
        rd_chk(7'h3F, 8'h22);
        wr_op(7'h03, 8'h18);
        chk({7'h00, bank}, 8'h00);
        rd_chk(7'h04, 8'hA0);
        rd_chk(7'h00, 8'h11);
        foreach (regs0[i]) rd_chk(regs0[i], 8'h50 + 8'(i));
        // bank 0 ram starts at 20h, so only low holes here
        foreach (holes0[i]) wr_op(holes0[i], 8'hFF);
        foreach (holes0[i]) rd_chk(holes0[i], 8'h00);
        rd_chk(7'h70, 8'h33);
        rd_chk(7'h7F, 8'h44);
        wr_op(7'h20, 8'h66);
        wr_op(7'h04, 8'hF5);
        wr_op(7'h00, 8'h3C);
        rd_chk(7'h75, 8'h3C);
        wr_op(7'h04, 8'h25);
        wr_op(7'h00, 8'h5C);
        rd_chk(7'h25, 8'h5C);
        rd_chk(7'h00, 8'h5C);
        wr_op(7'h04, 8'hA0);
        rd_chk(7'h00, 8'h11);
        wr_op(7'h04, 8'hC0);
        rd_chk(7'h00, 8'h00);
        wr_op(7'h04, 8'h80);
        wr_op(7'h00, 8'h7E);
        rd_chk(7'h00, 8'h00);
        chk(pointer, 8'h80);
        wr_op(7'h04, 8'h00);
        wr_op(7'h00, 8'h7E);
        rd_chk(7'h00, 8'h00);
        rd_chk(7'h03, 8'h18);
        // read and write in one cycle: read sees the old byte
        core_u.access(1'b1, 1'b1, 7'h20, 8'hE1, q, v);
        chk({7'h00, v}, 8'h01);
        chk(q, 8'h66);
        rd_chk(7'h20, 8'hE1);
        // second reset, dropped on an edge, clears the storage
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(pointer, 8'h00);
        rd_chk(7'h20, 8'h00);
        report_and_stop();
    end
endmodule
